// >>> tlc_regs.svh
// offsets, field masks and reset values of the temperature limit bank
`ifndef TLC_REGS_SVH
`define TLC_REGS_SVH

// ----------------------------------------------------------------------
// byte offsets of the limit bank
// ----------------------------------------------------------------------
`define TLC_OFS_HIGH_LIMIT_LOWER      8'h1C
`define TLC_OFS_HIGH_LIMIT_UPPER      8'h1D
`define TLC_OFS_LOW_LIMIT_LOWER       8'h1E
`define TLC_OFS_LOW_LIMIT_UPPER       8'h1F
`define TLC_OFS_CRIT_HIGH_LIMIT_LOWER 8'h20
`define TLC_OFS_CRIT_HIGH_LIMIT_UPPER 8'h21
`define TLC_OFS_CRIT_LOW_LIMIT_LOWER  8'h22
`define TLC_OFS_CRIT_LOW_LIMIT_UPPER  8'h23
`define TLC_NUM_BYTES                 8

// ----------------------------------------------------------------------
// writable bits: lower bytes lose bits 1:0, upper bytes lose bits 7:5
// ----------------------------------------------------------------------
`define TLC_LOWER_WMASK 8'hFC
`define TLC_UPPER_WMASK 8'h1F
`define TLC_LIMIT_SIGN  12

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TLC_RST_HIGH_LIMIT_LOWER      8'h70
`define TLC_RST_HIGH_LIMIT_UPPER      8'h03
`define TLC_RST_LOW_LIMIT_LOWER       8'h00
`define TLC_RST_LOW_LIMIT_UPPER       8'h00
`define TLC_RST_CRIT_HIGH_LIMIT_LOWER 8'h50
`define TLC_RST_CRIT_HIGH_LIMIT_UPPER 8'h05
`define TLC_RST_CRIT_LOW_LIMIT_LOWER  8'h00
`define TLC_RST_CRIT_LOW_LIMIT_UPPER  8'h00

`endif

// >>> tlc_pkg.sv
// types shared by the temperature limit bank
package tlc_pkg;
	typedef logic [7:0] tlc_byte_t;
	typedef logic [2:0] tlc_index_t;
	// which threshold a comparator serves
	typedef enum logic [1:0] {
		TLC_KIND_HIGH      = 2'h0,
		TLC_KIND_LOW       = 2'h1,
		TLC_KIND_CRIT_HIGH = 2'h2,
		TLC_KIND_CRIT_LOW  = 2'h3
	} tlc_kind_t;
endpackage

// >>> tlc_cmp.sv
// one signed threshold comparator for a limit byte pair
module tlc_cmp #(
	parameter int        TEMP_W = 16,
	parameter tlc_pkg::tlc_kind_t KIND = tlc_pkg::TLC_KIND_HIGH
) (
	// operands
	input  wire logic [TEMP_W-1:0] result,
	input  wire logic [15:0]       limit,
	// verdict
	output logic                   hit
);
	import tlc_pkg::*;
	`include "tlc_regs.svh"

	logic signed [TEMP_W-1:0] limit_ext;

	// sign-extend the 13 live bits so both operands share width and alignment
	assign limit_ext = {{(TEMP_W-`TLC_LIMIT_SIGN){limit[`TLC_LIMIT_SIGN]}},
		limit[`TLC_LIMIT_SIGN-1:0]};

	// strict comparison in the direction of this threshold
	always_comb begin
		if (KIND == TLC_KIND_HIGH || KIND == TLC_KIND_CRIT_HIGH) begin
			hit = $signed(result) > limit_ext;
		end else begin
			hit = $signed(result) < limit_ext;
		end
	end
endmodule

// >>> tlc_top.sv
// temperature limit register bank with four threshold status flags
// ----------------------------------------------------------------------
// What this block does
// - high flag set when result exceeds high limit
// - low flag set when result below low limit
// - critical high flag when result exceeds it
// - critical low flag when result below it
// - read-only-zero bits ignore writes, read zero
// - limit is upper byte above lower byte
// - high limit upper byte resets to 03
// - critical high bytes reset to 50, 05
// - low limit bytes both reset to zero
// - critical low lower byte resets to zero
// - high limit lower byte resets to 70
// - all flags follow the latest conversion or a later clear
// ----------------------------------------------------------------------
module tlc_top #(
	parameter int TEMP_W = 16
) (
	// clock, reset, enable
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	// register port from the serial interface
	input  wire tlc_pkg::tlc_byte_t    REG_ADDR,
	input  wire tlc_pkg::tlc_byte_t    REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output tlc_pkg::tlc_byte_t         REG_RDATA,
	output logic                       REG_RVALID,
	// conversion result from the converter
	input  wire logic [TEMP_W-1:0]     CONV_RESULT,
	input  wire logic                  CONV_VALID,
	// flag clear from the status logic, one bit per flag
	input  wire logic [3:0]            FLAG_CLEAR,
	// threshold flags
	output logic                       FLAG_HIGH,
	output logic                       FLAG_LOW,
	output logic                       FLAG_CRIT_HIGH,
	output logic                       FLAG_CRIT_LOW
);
	import tlc_pkg::*;
	`include "tlc_regs.svh"

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (TEMP_W < 13 || TEMP_W > 32) begin : g_bad_width
		$error("TEMP_W must lie between 13 and 32");
	end

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	// true when the address falls inside the limit bank
	function automatic logic in_bank(input tlc_byte_t a);
		in_bank = (a >= `TLC_OFS_HIGH_LIMIT_LOWER) && (a <= `TLC_OFS_CRIT_LOW_LIMIT_UPPER);
	endfunction

	// bank index of an address
	function automatic tlc_index_t bank_index(input tlc_byte_t a);
		tlc_byte_t d;
		d = a - `TLC_OFS_HIGH_LIMIT_LOWER;
		bank_index = d[2:0];
	endfunction

	// writable bits of a byte: odd index is an upper byte
	function automatic tlc_byte_t write_mask(input tlc_index_t i);
		write_mask = i[0] ? `TLC_UPPER_WMASK : `TLC_LOWER_WMASK;
	endfunction

	// reset value of each byte
	function automatic tlc_byte_t reset_value(input tlc_index_t i);
		case (i)
			3'h0:    reset_value = `TLC_RST_HIGH_LIMIT_LOWER;
			3'h1:    reset_value = `TLC_RST_HIGH_LIMIT_UPPER;
			3'h2:    reset_value = `TLC_RST_LOW_LIMIT_LOWER;
			3'h3:    reset_value = `TLC_RST_LOW_LIMIT_UPPER;
			3'h4:    reset_value = `TLC_RST_CRIT_HIGH_LIMIT_LOWER;
			3'h5:    reset_value = `TLC_RST_CRIT_HIGH_LIMIT_UPPER;
			3'h6:    reset_value = `TLC_RST_CRIT_LOW_LIMIT_LOWER;
			default: reset_value = `TLC_RST_CRIT_LOW_LIMIT_UPPER;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// limit storage and read path
	// ------------------------------------------------------------------
	tlc_byte_t  bank        [`TLC_NUM_BYTES];
	tlc_byte_t  next_bank   [`TLC_NUM_BYTES];
	tlc_byte_t  next_rdata;
	logic       next_rvalid;
	logic       hit_bank;
	tlc_index_t idx;

	assign hit_bank = in_bank(REG_ADDR);
	assign idx      = bank_index(REG_ADDR);

	// write keeps only writable bits; a read of a stray address returns zero
	always_comb begin
		for (int i = 0; i < `TLC_NUM_BYTES; i++) begin
			next_bank[i] = bank[i];
		end
		if (REG_WR && hit_bank) begin
			next_bank[idx] = REG_WDATA & write_mask(idx);
		end
		next_rdata  = (REG_RD && hit_bank) ? bank[idx] : 8'h00;
		next_rvalid = REG_RD;
	end

	// bank registers, frozen while the enable is low
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			for (int i = 0; i < `TLC_NUM_BYTES; i++) begin
				bank[i] <= reset_value(3'(i));
			end
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end else if (CE) begin
			for (int i = 0; i < `TLC_NUM_BYTES; i++) begin
				bank[i] <= next_bank[i];
			end
			REG_RDATA  <= next_rdata;
			REG_RVALID <= next_rvalid;
		end
	end

	// ------------------------------------------------------------------
	// threshold comparators
	// ------------------------------------------------------------------
	logic [3:0] hit;
	logic [3:0] flag;
	logic [3:0] next_flag;

	// each limit is its upper byte above its lower byte
	for (genvar k = 0; k < 4; k++) begin : g_cmp
		tlc_cmp #(
			.TEMP_W (TEMP_W),
			.KIND   (tlc_kind_t'(k))
		) u_cmp (
			.result (CONV_RESULT),
			.limit  ({bank[2*k+1], bank[2*k]}),
			.hit    (hit[k])
		);
	end

	// a finished conversion rewrites every flag; it wins over a clear
	always_comb begin
		if (CONV_VALID) begin
			next_flag = hit;
		end else begin
			next_flag = flag & ~FLAG_CLEAR;
		end
	end

	// flag registers
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			flag <= 4'h0;
		end else if (CE) begin
			flag <= next_flag;
		end
	end

	assign FLAG_HIGH      = flag[TLC_KIND_HIGH];
	assign FLAG_LOW       = flag[TLC_KIND_LOW];
	assign FLAG_CRIT_HIGH = flag[TLC_KIND_CRIT_HIGH];
	assign FLAG_CRIT_LOW  = flag[TLC_KIND_CRIT_LOW];

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	// reference limits, built independently of the comparator instances
	logic signed [15:0] ref_lim [4];
	for (genvar k = 0; k < 4; k++) begin : g_ref
		assign ref_lim[k] = $signed({{3{bank[2*k+1][4]}}, bank[2*k+1][4:0], bank[2*k]});
	end

	sequence s_conv;
		CE && CONV_VALID;
	endsequence

	sequence s_bank_write;
		CE && REG_WR && hit_bank;
	endsequence

	chk_flag_high_set: assert property (s_conv |=> FLAG_HIGH ==
		($past($signed(CONV_RESULT)) > $past(ref_lim[0])))
		else $error("high flag disagrees with last conversion");
	chk_flag_low_set: assert property (s_conv |=> FLAG_LOW ==
		($past($signed(CONV_RESULT)) < $past(ref_lim[1])))
		else $error("low flag disagrees with last conversion");
	chk_flag_crit_high: assert property (s_conv |=> FLAG_CRIT_HIGH ==
		($past($signed(CONV_RESULT)) > $past(ref_lim[2])))
		else $error("critical high flag disagrees with last conversion");
	chk_flag_crit_low: assert property (s_conv |=> FLAG_CRIT_LOW ==
		($past($signed(CONV_RESULT)) < $past(ref_lim[3])))
		else $error("critical low flag disagrees with last conversion");
	chk_flags_hold_idle: assert property (!CE |=> $stable(flag))
		else $error("flags moved while enable low");
	chk_write_masked: assert property (s_bank_write |=>
		bank[$past(idx)] == ($past(REG_WDATA) & write_mask($past(idx))))
		else $error("limit write not masked");
	// a held answer while the enable was low belongs to an older address
	chk_ro_upper_zero: assert property (REG_RVALID && $past(CE) && $past(idx[0])
		&& $past(hit_bank) |-> REG_RDATA[7:5] == 3'h0)
		else $error("upper byte read-only bits not zero");
	chk_ro_lower_zero: assert property (REG_RVALID && $past(CE) && !$past(idx[0])
		&& $past(hit_bank) |-> REG_RDATA[1:0] == 2'h0)
		else $error("lower byte read-only bits not zero");
	chk_rst_high_limit: assert property ($past(RST) |->
		bank[1] == 8'h03 && bank[0] == 8'h70)
		else $error("high limit reset value wrong");
	chk_rst_crit_high: assert property ($past(RST) |->
		bank[4] == 8'h50 && bank[5] == 8'h05)
		else $error("critical high reset value wrong");
	chk_rst_low_limit: assert property ($past(RST) |->
		bank[2] == 8'h00 && bank[3] == 8'h00 && bank[6] == 8'h00)
		else $error("low limit reset value wrong");
	// every comparator verdict against the independently paired limits
	chk_limit_pairing: assert property (hit == {
		$signed(CONV_RESULT) < ref_lim[3], $signed(CONV_RESULT) > ref_lim[2],
		$signed(CONV_RESULT) < ref_lim[1], $signed(CONV_RESULT) > ref_lim[0]})
		else $error("limit pairing wrong");
	chk_stray_read_zero: assert property (CE && REG_RD && !hit_bank |=> REG_RDATA == 8'h00)
		else $error("stray address read not zero");
endmodule

// >>> tlc_host.sv
// host model driving the register port of the limit bank
module tlc_host (
	// clock
	input  wire logic          CLOCK,
	// register port
	output tlc_pkg::tlc_byte_t REG_ADDR,
	output tlc_pkg::tlc_byte_t REG_WDATA,
	output logic               REG_WR,
	output logic               REG_RD
);
	timeunit 1ns;
	timeprecision 1ps;
	import tlc_pkg::*;
	// idle port at time zero
	initial begin
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
	end
	// one byte cycle; the idle port shows the inverse of the last value
	task automatic xfer(input tlc_byte_t a, input tlc_byte_t d, input logic wr);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= wr;
		REG_RD <= ~wr;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		REG_ADDR <= ~a;
		REG_WDATA <= ~d;
	endtask
endmodule

// >>> temp_limit_compare_regs_tb.sv
// self-checking bench of the temperature limit bank
module temp_limit_compare_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tlc_pkg::*;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic CE = 1'b1;
	logic CONV_VALID = 1'b0;
	logic [15:0] CONV_RESULT = 16'h0000;
	logic [3:0] FLAG_CLEAR = 4'h0;
	tlc_byte_t REG_ADDR, REG_WDATA, REG_RDATA;
	logic REG_WR, REG_RD, REG_RVALID, ev;
	logic [3:0] FL, cur_f;
	tlc_byte_t bank [8] = '{8'h70, 8'h03, 8'h00, 8'h00, 8'h50, 8'h05, 8'h00, 8'h00};
	logic [15:0] edge_r [6] = '{16'h0370, 16'h0371, 16'h0550, 16'h0551, 16'h0000, 16'hFFFF};
	logic [7:0] rq [$];
	logic [3:0] fq [$];
	int fails = 0;
	int n_compared = 0;
	int h, l;
	// ------------------------------------------------------------
	// clock, parts
	// ------------------------------------------------------------
	always #10 CLOCK = ~CLOCK;
	tlc_host u_host (.CLOCK(CLOCK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD));
	tlc_top u_dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .CONV_RESULT(CONV_RESULT), .CONV_VALID(CONV_VALID),
		.FLAG_CLEAR(FLAG_CLEAR), .FLAG_HIGH(FL[0]), .FLAG_LOW(FL[1]),
		.FLAG_CRIT_HIGH(FL[2]), .FLAG_CRIT_LOW(FL[3]));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// expected flags from the shadow bank, signed 13-bit limits
	function automatic logic [3:0] flags_of(input logic [15:0] r);
		logic signed [12:0] lim [4];
		for (int k = 0; k < 4; k++) lim[k] = {bank[2*k+1][4:0], bank[2*k]};
		return {$signed(r) < lim[3], $signed(r) > lim[2], $signed(r) < lim[1], $signed(r) > lim[0]};
	endfunction
	function automatic logic mapped(input tlc_byte_t a);
		return a >= 8'h1C && a <= 8'h23;
	endfunction
	task automatic rd(input tlc_byte_t a);
		rq.push_back(mapped(a) ? bank[a-8'h1C] : 8'h00);
		u_host.xfer(a, 8'h00, 1'b0);
	endtask
	task automatic wr(input tlc_byte_t a, input tlc_byte_t d);
		if (mapped(a)) bank[a-8'h1C] = d & (a[0] ? 8'h1F : 8'hFC);
		u_host.xfer(a, d, 1'b1);
	endtask
	// limit k: upper byte above lower byte
	task automatic setlim(input int k, input logic [12:0] v);
		wr(8'(8'h1D + 2*k), {3'h0, v[12:8]});
		wr(8'(8'h1C + 2*k), v[7:0]);
	endtask
	// a conversion (cv high) or a clear alone, with its expected flags noted
	task automatic conv(input logic cv, input logic [15:0] r, input logic [3:0] clr);
		@(posedge CLOCK);
		CONV_VALID <= cv;
		CONV_RESULT <= r;
		FLAG_CLEAR <= clr;
		cur_f = cv ? flags_of(r) : cur_f & ~clr;
		fq.push_back(cur_f);
		@(posedge CLOCK);
		CONV_VALID <= 1'b0;
		FLAG_CLEAR <= 4'h0;
		CONV_RESULT <= ~r;
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// monitor: answers are taken against the oldest note
	always @(posedge CLOCK) begin
		if (REG_RVALID === 1'b1) check("rdata", rq.size() ? rq.pop_front() : 8'hXX, REG_RDATA);
		if (ev) check("flags", fq.size() ? fq.pop_front() : 4'hX, FL);
		ev = !RST && CE && (CONV_VALID || |FLAG_CLEAR);
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h788cb682));
		cur_f = 4'h0;
		ev = 1'b0;
		repeat (4) @(posedge CLOCK);
		RST <= 1'b0;
		for (int a = 8'h1B; a <= 8'h24; a++) rd(8'(a));
		$display("test reset_values done");
		foreach (edge_r[i]) conv(1'b1, edge_r[i], 4'h0);
		$display("test default_limits done");
		for (int a = 8'h1B; a <= 8'h24; a++) wr(8'(a), 8'hFF);
		for (int a = 8'h1B; a <= 8'h24; a++) rd(8'(a));
		for (int i = -5; i <= -3; i++) conv(1'b1, 16'(i), 4'h0);
		$display("test readonly_bits done");
		conv(1'b1, 16'h0000, 4'h0);
		conv(1'b0, 16'h0000, 4'h1);
		conv(1'b1, 16'h0000, 4'hF);
		conv(1'b0, 16'h0000, 4'hF);
		$display("test flag_clear done");
		// enable low: a write and a conversion are both ignored
		@(posedge CLOCK);
		CE <= 1'b0;
		u_host.xfer(8'h1C, 8'h00, 1'b1);
		CONV_VALID <= 1'b1;
		CONV_RESULT <= 16'h8000;
		@(posedge CLOCK);
		CONV_VALID <= 1'b0;
		CE <= 1'b1;
		check("held flags", 8'(cur_f), 8'(FL));
		rd(8'h1C);
		$display("test clock_enable done");
		for (int n = 0; n < 12; n++) begin
			h = 4 * $urandom_range(0, 800);
			l = -4 * $urandom_range(0, 400);
			setlim(0, 13'(h));
			setlim(2, 13'(h + 4 * $urandom_range(1, 200)));
			setlim(1, 13'(l));
			setlim(3, 13'(l - 4 * $urandom_range(1, 200)));
			repeat (4) conv(1'b1, 16'($urandom_range(0, 9000) - 4500), 4'h0);
			conv(1'b0, 16'h0000, 4'($urandom));
			rd(8'($urandom_range(8'h1B, 8'h24)));
		end
		$display("test random_limits done");
		for (int i = 0; i < 10 && (rq.size() || fq.size()); i++) @(posedge CLOCK);
		if (rq.size() || fq.size()) fails++;
		print_verdict();
	end
endmodule
